/* File: coherent_module_mdio_map_defines.vh */
// register map, field positions, frame codes and timing for the mdio register bank
// assumes a 100 MHz system clock and a clause 45 station manager on the bus
`ifndef COHERENT_MODULE_MDIO_MAP_DEFINES_VH
`define COHERENT_MODULE_MDIO_MAP_DEFINES_VH

// register addresses and table ranges
`define MAP_W_STATUS      16'hB050
`define MAP_VNVR_LO       16'h8400
`define MAP_VNVR_HI       16'h84FF
`define MAP_UNVR_LO       16'h8800
`define MAP_UNVR_HI       16'h88FF
`define MAP_UPRIV_LO      16'h8F00
`define MAP_UPRIV_HI      16'h8FFF
`define MAP_VPRIV_LO      16'h9000
`define MAP_VPRIV_HI      16'h9FFF
`define MAP_CAL_LO        16'hBAE0
`define MAP_CAL_HI        16'hBAFF
`define MAP_PIN_CFG       16'hBB00
`define MAP_PIN_STAT      16'hBB01
`define MAP_PM_CUR        16'hBB10
`define MAP_PM_AVG        16'hBB11
`define MAP_PM_MIN        16'hBB12
`define MAP_PM_MAX        16'hBB13

// pin configuration fields
`define CFG_CTL_MODE      0
`define CFG_ALRM_MODE     1
`define CFG_TICK_EXT      2
`define CFG_ALRM_LEVEL    3
`define CFG_W             4
`define CFG_RESET         4'h0
`define W_STATUS_VALUE    16'h0000

// clause 45 frame
`define OP_ADDR           2'h0
`define OP_WRITE          2'h1
`define OP_RDINC          2'h2
`define OP_READ           2'h3
`define PREAMBLE_MIN      6'h20
`define HDR_LAST          5'h0C
`define DATA_LAST         5'h0F
`define TA_FIRST          5'h00
`define DEV_ADDR          5'h01

// timing
`define CLK_MHZ           100
`define MONITOR_INTERVAL_TICK_MS        1000
`define PM_SAMPLE_US      10
`define MONITOR_INTERVAL_TICK_CYC       (`MONITOR_INTERVAL_TICK_MS * 1000 * `CLK_MHZ)
`define PM_SAMPLE_CYC     (`PM_SAMPLE_US * `CLK_MHZ)
`define EMA_SHIFT         3

`endif

/* File: mgmt_memory.v */
// word memory for the user non-volatile and user private tables
// assumes one writer and one reader on the same clock; read data are registered
`timescale 1ns/100ps
module mgmt_memory #(
	parameter DATA_W = 16,
	parameter ADDR_W = 9
) (
	input  wire              clock,       // system clock
	input  wire              writeEnable, // one-cycle write strobe
	input  wire [ADDR_W-1:0] writeAddr,   // write index
	input  wire [DATA_W-1:0] writeData,   // write word
	input  wire [ADDR_W-1:0] readAddr,    // read index
	output reg  [DATA_W-1:0] readData     // word at readAddr, one cycle late
);
	reg [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

	// no reset on the array: contents model retained storage
	always @(posedge clock) begin
		if (writeEnable) begin
			cells[writeAddr] <= writeData;
		end
		readData <= cells[readAddr];
	end
endmodule // mgmt_memory

/* File: coherent_module_mdio_map.v */
// clause 45 mdio register bank with pin repurposing and monitor statistics
// assumes mdc, mdio, port address and pins are asynchronous; monitoredValue and rxSignalLoss are on clock
`timescale 1ns/100ps
`include "coherent_module_mdio_map_defines.vh"
module coherent_module_mdio_map #(
	parameter        TICK_CYCLES   = `MONITOR_INTERVAL_TICK_CYC, // internal monitor interval in cycles
	parameter [7:0]  VENDOR_FILL   = 8'hA5,        // arbitrary vendor table content
	parameter [15:0] PRIVATE_FILL  = 16'h0000,     // vendor private page content
	parameter [15:0] CAL_FILL      = 16'h0000      // calibration word content
) (
	input  wire        clock,                        // 100 MHz system clock
	input  wire        nrst,                         // asynchronous reset, active low
	input  wire        mdc,                          // management clock pin
	input  wire        mdioIn,                       // management data pin level
	output reg         mdioOut,                      // management data drive value
	output reg         mdioOe,                       // high while driving mdio
	input  wire [4:0]  portAddress,                  // strapped port address pins
	input  wire        transmitDisableInput,         // transmit-disable pin
	input  wire        secondProgrammableControlPin, // monitor sync input pin
	input  wire        rxSignalLoss,                 // internal loss-of-signal status
	input  wire [15:0] monitoredValue,               // monitored variable sample
	output reg         txDisable,                    // transmit disable to the optics
	output reg         programmableControlPin,       // control level when repurposed
	output reg         receiveSignalLossOutput       // loss-of-signal or alarm pin
);
	localparam S_PRE  = 4'b0001;
	localparam S_HDR  = 4'b0010;
	localparam S_TA   = 4'b0100;
	localparam S_DATA = 4'b1000;
	localparam [31:0] SAMPLE_CYCLES = `PM_SAMPLE_CYC;

	reg        rstMeta, rstN;
	reg  [8:0] pinMeta, pinSync;
	reg        mdcPrev, syncPrev;
	reg  [3:0] state;
	reg  [5:0] ones;
	reg  [4:0] bitCnt;
	reg [11:0] hdr;
	reg  [1:0] op;
	reg        sel;
	reg [15:0] shift, addrReg;
	reg [15:0] readWord;
	reg  [`CFG_W-1:0] cfg;
	reg        memWe;
	reg  [8:0] memWa;
	reg [15:0] memWd;
	wire [15:0] memRd;
	reg [31:0] tickCnt, sampleCnt;
	reg [15:0] runMin, runMax, runAvg;
	reg [15:0] pmCur, pmAvg, pmMin, pmMax;

	wire        mdcLvl   = pinSync[0];
	wire        bitIn    = pinSync[1];
	wire [4:0]  portSync = pinSync[6:2];
	wire        txDisSync = pinSync[7];
	wire        syncLvl  = pinSync[8];
	wire        mdcRise  = mdcLvl & ~mdcPrev;
	wire [12:0] hdrNext  = {hdr, bitIn};
	wire [15:0] dataNext = {shift[14:0], bitIn};
	wire        isUnvr   = (addrReg >= `MAP_UNVR_LO) && (addrReg <= `MAP_UNVR_HI);
	wire        isUpriv  = (addrReg >= `MAP_UPRIV_LO) && (addrReg <= `MAP_UPRIV_HI);
	wire [8:0]  memRa    = {isUpriv, addrReg[7:0]};
	wire        sampleHit = (sampleCnt == SAMPLE_CYCLES - 32'h1);
	wire        tickWrap = (tickCnt == TICK_CYCLES - 1);
	wire        monitorIntervalTick = cfg[`CFG_TICK_EXT] ? (syncLvl & ~syncPrev) : tickWrap;
	wire [16:0] emaDiff  = {1'b0, monitoredValue} - {1'b0, runAvg};
	wire [15:0] emaStep  = emaDiff[16] ? ~(~emaDiff[15:0] >> `EMA_SHIFT) : (emaDiff[15:0] >> `EMA_SHIFT);

	// reset release through two flops
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// every pin passes two flops before use
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pinMeta  <= 9'h000;
			pinSync  <= 9'h000;
			mdcPrev  <= 1'b0;
			syncPrev <= 1'b0;
		end else begin
			pinMeta  <= {secondProgrammableControlPin, transmitDisableInput, portAddress, mdioIn, mdc};
			pinSync  <= pinMeta;
			mdcPrev  <= mdcLvl;
			syncPrev <= syncLvl;
		end
	end

	// read multiplexer; unmapped addresses read zero
	always @* begin
		readWord = 16'h0000;
		if (addrReg >= `MAP_VNVR_LO && addrReg <= `MAP_VNVR_HI)
			readWord = {8'h00, VENDOR_FILL};
		else if (isUnvr || isUpriv)
			readWord = memRd;
		else if (addrReg >= `MAP_VPRIV_LO && addrReg <= `MAP_VPRIV_HI)
			readWord = PRIVATE_FILL;
		else if (addrReg >= `MAP_CAL_LO && addrReg <= `MAP_CAL_HI)
			readWord = CAL_FILL;
		else begin
			case (addrReg)
				`MAP_W_STATUS: readWord = `W_STATUS_VALUE;
				`MAP_PIN_CFG:  readWord = {{(16-`CFG_W){1'b0}}, cfg};
				`MAP_PIN_STAT: readWord = {13'h0, rxSignalLoss, txDisSync, syncLvl};
				`MAP_PM_CUR:   readWord = pmCur;
				`MAP_PM_AVG:   readWord = pmAvg;
				`MAP_PM_MIN:   readWord = pmMin;
				`MAP_PM_MAX:   readWord = pmMax;
				default:       readWord = 16'h0000;
			endcase
		end
	end

	// clause 45 frame engine; output changes just after the mdc rising edge it follows
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state   <= S_PRE;
			ones    <= 6'h00;
			bitCnt  <= 5'h00;
			hdr     <= 12'h000;
			op      <= 2'h0;
			sel     <= 1'b0;
			shift   <= 16'h0000;
			addrReg <= 16'h0000;
			cfg     <= `CFG_RESET;
			memWe   <= 1'b0;
			memWa   <= 9'h000;
			memWd   <= 16'h0000;
			mdioOut <= 1'b0;
			mdioOe  <= 1'b0;
		end else begin
			memWe <= 1'b0;
			if (mdcRise) begin
				case (state)
					S_PRE: begin
						if (bitIn)
							ones <= (ones == `PREAMBLE_MIN) ? ones : ones + 6'h01;
						else begin
							// start bit after a full preamble
							if (ones == `PREAMBLE_MIN) begin
								state  <= S_HDR;
								bitCnt <= 5'h00;
							end
							ones <= 6'h00;
						end
					end
					S_HDR: begin
						hdr    <= hdrNext[11:0];
						bitCnt <= bitCnt + 5'h01;
						if (bitCnt == `HDR_LAST) begin
							op     <= hdrNext[11:10];
							sel    <= ~hdrNext[12] && (hdrNext[9:5] == portSync) && (hdrNext[4:0] == `DEV_ADDR);
							state  <= S_TA;
							bitCnt <= 5'h00;
						end
					end
					S_TA: begin
						bitCnt <= bitCnt + 5'h01;
						if (bitCnt == `TA_FIRST) begin
							mdioOe  <= sel & op[1];
							mdioOut <= 1'b0;
						end else begin
							mdioOut <= readWord[15];
							shift   <= {readWord[14:0], 1'b0};
							state   <= S_DATA;
							bitCnt  <= 5'h00;
						end
					end
					S_DATA: begin
						bitCnt <= bitCnt + 5'h01;
						if (op[1]) begin
							mdioOut <= shift[15];
							shift   <= {shift[14:0], 1'b0};
						end else
							shift <= dataNext;
						if (bitCnt == `DATA_LAST) begin
							state   <= S_PRE;
							mdioOe  <= 1'b0;
							mdioOut <= 1'b0;
							if (sel) begin
								if (op == `OP_ADDR)
									addrReg <= dataNext;
								else if (op == `OP_RDINC)
									addrReg <= addrReg + 16'h0001;
								else if (op == `OP_WRITE) begin
									// function and level change at any time
									if (addrReg == `MAP_PIN_CFG)
										cfg <= dataNext[`CFG_W-1:0];
									// byte tables keep low byte only
									memWe <= isUnvr | isUpriv;
									memWa <= memRa;
									memWd <= isUnvr ? {8'h00, dataNext[7:0]} : dataNext;
								end
							end
						end
					end
					default: state <= S_PRE;
				endcase
			end
		end
	end

	// pin functions, legacy after reset
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			txDisable               <= 1'b0;
			programmableControlPin  <= 1'b0;
			receiveSignalLossOutput <= 1'b0;
		end else begin
			txDisable              <= cfg[`CFG_CTL_MODE] ? 1'b0 : txDisSync;
			programmableControlPin <= cfg[`CFG_CTL_MODE] ? txDisSync : 1'b0;
			receiveSignalLossOutput <= cfg[`CFG_ALRM_MODE] ? cfg[`CFG_ALRM_LEVEL] : rxSignalLoss;
		end
	end

	// running statistics; the average is exponential, cheaper than a divider
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			tickCnt   <= 32'h0;
			sampleCnt <= 32'h0;
			runMin    <= 16'hFFFF;
			runMax    <= 16'h0000;
			runAvg    <= 16'h0000;
			pmCur     <= 16'h0000;
			pmAvg     <= 16'h0000;
			pmMin     <= 16'h0000;
			pmMax     <= 16'h0000;
		end else begin
			tickCnt   <= tickWrap ? 32'h0 : tickCnt + 32'h1;
			sampleCnt <= sampleHit ? 32'h0 : sampleCnt + 32'h1;
			pmCur     <= monitoredValue;
			if (monitorIntervalTick) begin
				pmAvg  <= runAvg;
				pmMin  <= runMin;
				pmMax  <= runMax;
				runMin <= monitoredValue;
				runMax <= monitoredValue;
				runAvg <= monitoredValue;
			end else if (sampleHit) begin
				runMin <= (monitoredValue < runMin) ? monitoredValue : runMin;
				runMax <= (monitoredValue > runMax) ? monitoredValue : runMax;
				runAvg <= runAvg + emaStep;
			end
		end
	end

	mgmt_memory #(
		.DATA_W (16),
		.ADDR_W (9)
	) userTables (
		.clock       (clock),
		.writeEnable (memWe),
		.writeAddr   (memWa),
		.writeData   (memWd),
		.readAddr    (memRa),
		.readData    (memRd)
	);
endmodule // coherent_module_mdio_map

/* File: coherent_module_mdio_map_properties.sv */
// checker for the mdio register bank: drive timing and pin steering
// assumes it is bound to the bank top and sees only its ports
`timescale 1ns/100ps
module coherent_module_mdio_map_check (
	input wire logic clock,                 // system clock
	input wire logic nrst,                  // reset, active low
	input wire logic mdc,                   // management clock pin
	input wire logic mdioOut,               // data drive value
	input wire logic mdioOe,                // data drive enable
	input wire logic transmitDisableInput,  // transmit-disable pin
	input wire logic txDisable,             // disable to the optics
	input wire logic programmableControlPin // repurposed control level
);
	logic       mdcLast;
	logic [7:0] sinceMdc;
	logic [7:0] oeRun;
	logic       heldLow = 1'b0;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// clocks since an mdc rise was seen, and length of a drive burst
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mdcLast  <= 1'b0;
			sinceMdc <= 8'hFF;
			oeRun    <= 8'h00;
		end else begin
			mdcLast  <= mdc;
			sinceMdc <= (mdc && !mdcLast) ? 8'h00 : ((sinceMdc == 8'hFF) ? sinceMdc : sinceMdc + 8'h01);
			oeRun    <= mdioOe ? oeRun + 8'h01 : 8'h00;
		end
	end
	// reset also low on the edge before, so the asynchronous clear has landed and no start-up unknown is judged
	always @(posedge clock) begin
		heldLow <= !nrst;
	end
	sequence s_turn;
		$rose(mdioOe) && !mdioOut;
	endsequence
	sequence s_hold;
		mdioOe [*8];
	endsequence
	AST_TA_ZERO: assert property ($rose(mdioOe) |-> !mdioOut) else $error("turnaround bit not zero");
	AST_DRIVE_HOLD: assert property (s_turn |=> s_hold) else $error("drive burst too short");
	AST_DRIVE_BOUND: assert property (oeRun < 8'd240) else $error("drive burst too long");
	AST_DRIVE_AT_MDC: assert property (($changed(mdioOut) || $changed(mdioOe)) |-> sinceMdc inside {[8'd1:8'd8]})
		else $error("mdio drive moved away from an mdc rise");
	AST_PIN_EXCL: assert property (!(txDisable && programmableControlPin)) else $error("both pin uses active");
	AST_TX_SOURCE: assert property (txDisable |-> $past(transmitDisableInput, 3))
		else $error("tx disable without pin");
	AST_CTL_SOURCE: assert property (programmableControlPin |-> $past(transmitDisableInput, 3))
		else $error("control level without pin");
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		(!nrst && heldLow) |-> !mdioOe && !txDisable && !programmableControlPin)
		else $error("output active in reset");
endmodule // coherent_module_mdio_map_check
bind coherent_module_mdio_map coherent_module_mdio_map_check chk_u (.clock(clock), .nrst(nrst), .mdc(mdc),
	.mdioOut(mdioOut), .mdioOe(mdioOe), .transmitDisableInput(transmitDisableInput), .txDisable(txDisable),
	.programmableControlPin(programmableControlPin));

/* File: mdio_host_model.sv */
// station manager model: clause 45 frames, msb first, 125 ns bit time
// assumes the bench resolves the wire with a pull-up and returns it as line
`timescale 1ns/100ps
`include "coherent_module_mdio_map_defines.vh"
module mdio_host_model (
	input  wire  clock,   // bench clock; frames start just after its edge
	output logic mdc,     // management clock, still between frames
	output logic hostOe,  // high while the host drives mdio
	output logic hostBit, // host drive value
	input  wire  line     // resolved mdio wire
);
	initial {mdc, hostOe, hostBit} = 3'b001;
	// clause 45 frame
	// data move at mdc fall so they stand still across the rise
	task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] data,
		output logic [15:0] rdata);
		logic [63:0] bits;
		// align to just after a clock edge: a 62.5 ns step then never lands on a sampling edge
		@(posedge clock);
		#1;
		bits = {32'hFFFFFFFF, 2'b00, op, prt, `DEV_ADDR, 2'b10, data};
		rdata = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			hostOe = !(op[1] && i < 18); // reads hand the wire over at turnaround
			hostBit = bits[i];
			#62.5;
			if (i < 16)
				rdata[i] = line;
			mdc = 1'b1;
			#62.5;
			mdc = 1'b0;
		end
		hostOe = 1'b0;
	endtask
endmodule // mdio_host_model

/* File: tb_top.sv */
// self-checking bench for the mdio register bank: map, pins, monitor statistics
// assumes the station manager model and the bound checker compile alongside
`timescale 1ns/100ps
`include "coherent_module_mdio_map_defines.vh"
module tb_top;
	logic        clock = 1'b0, nrst = 1'b0, txIn = 1'b0, syncPin = 1'b0, rxLoss = 1'b0;
	logic [4:0]  portAddress = 5'h05;
	logic [15:0] monVal = 16'h0100;
	logic [15:0] rd;
	wire         mdc, hostOe, hostBit, mdioOut, mdioOe, txDisable, pcp, rlo;
	wire         line = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1); // pull-up when idle
	int          num_errors = 0, comparisons = 0, cycles = 0;
	// address, word written, word expected back (read-only places keep their fill)
	logic [15:0] adr [9] = '{16'h8800, 16'h8801, 16'h88FF, 16'h8F00, 16'h8FFF, 16'h8400, 16'h9000,
		16'hBAE0, 16'hB050};
	logic [15:0] dat [9] = '{16'h1234, 16'h5656, 16'hAB77, 16'hBEEF, 16'h0102, 16'h00FF, 16'hFFFF,
		16'hFFFF, 16'hFFFF};
	logic [15:0] exv [9] = '{16'h0034, 16'h0056, 16'h0077, 16'hBEEF, 16'h0102, 16'h003C, 16'h1234,
		16'h5678, 16'h0000};
	coherent_module_mdio_map #(.TICK_CYCLES(2000), .VENDOR_FILL(8'h3C), .PRIVATE_FILL(16'h1234),
		.CAL_FILL(16'h5678)) dut_u (.clock(clock), .nrst(nrst), .mdc(mdc), .mdioIn(line), .mdioOut(mdioOut),
		.mdioOe(mdioOe), .portAddress(portAddress), .transmitDisableInput(txIn),
		.secondProgrammableControlPin(syncPin), .rxSignalLoss(rxLoss), .monitoredValue(monVal),
		.txDisable(txDisable), .programmableControlPin(pcp), .receiveSignalLossOutput(rlo));
	mdio_host_model host_u (.clock(clock), .mdc(mdc), .hostOe(hostOe), .hostBit(hostBit), .line(line));
	always #5 clock = ~clock;
	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [4:0] p = 5'h05);
		host_u.frame(`OP_ADDR, p, a, rd);
		host_u.frame(`OP_WRITE, p, d, rd);
	endtask
	task automatic rdw(input logic [15:0] a, input logic [1:0] op = `OP_READ, input logic [4:0] p = 5'h05);
		host_u.frame(`OP_ADDR, p, a, rd);
		host_u.frame(op, p, 16'h0000, rd);
	endtask
	// pins pass two sync flops and an output flop; check off the edge
	task automatic settle();
		repeat (8) @(posedge clock);
		#1;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		settle();
		for (int i = 0; i < 9; i++) begin
			wr(adr[i], dat[i]);
			rdw(adr[i]);
			check("map word", rd, exv[i]);
		end
		rdw(16'h8800, `OP_RDINC);
		check("read increment", rd, 16'h0034);
		host_u.frame(`OP_READ, 5'h05, 16'h0000, rd);
		check("next word", rd, 16'h0056);
		wr(16'h8800, 16'h00EE, 5'h06);
		rdw(16'h8800, `OP_READ, 5'h06);
		check("foreign read", rd, 16'hFFFF);
		rdw(16'h8800);
		check("foreign write", rd, 16'h0034);
		$display("test map done");
		@(posedge clock);
		txIn <= 1'b1;
		rxLoss <= 1'b1;
		settle();
		check("tx disable", txDisable, 1'b1);
		check("loss pin", rlo, 1'b1);
		wr(`MAP_PIN_CFG, 16'h0003);
		settle();
		check("tx disable", txDisable, 1'b0);
		check("control pin", pcp, 1'b1);
		check("alarm pin", rlo, 1'b0);
		@(posedge clock);
		txIn <= 1'b0;
		wr(`MAP_PIN_CFG, 16'h000B);
		settle();
		check("control pin", pcp, 1'b0);
		check("alarm pin", rlo, 1'b1);
		rdw(`MAP_PIN_CFG);
		check("pin config", rd, 16'h000B);
		rdw(`MAP_PIN_STAT);
		check("pin status", rd, 16'h0004);
		$display("test pins done");
		for (int i = 0; i < 4; i++) begin
			rdw(`MAP_PM_CUR + i[15:0]);
			check("statistic", rd, 16'h0100);
		end
		wr(`MAP_PIN_CFG, 16'h0004);
		@(posedge clock);
		monVal <= 16'h0200;
		repeat (3000) @(posedge clock);
		rdw(`MAP_PM_MAX);
		check("max held", rd, 16'h0100);
		@(posedge clock);
		monVal <= 16'h0400;
		repeat (1500) @(posedge clock);
		// sync pulse, phases shortened to keep the run brief
		syncPin <= 1'b1;
		repeat (50) @(posedge clock);
		syncPin <= 1'b0;
		rdw(`MAP_PM_MIN);
		check("min at sync", rd, 16'h0100);
		rdw(`MAP_PM_MAX);
		check("max at sync", rd, 16'h0400);
		$display("test monitor done");
		report_and_stop();
	end
endmodule // tb_top
